// File: rtl/pefc_regs.svh
// Purpose: register addresses, bit positions and reset values of the power event block
// Assumes: 8-bit special-function register space, byte-wide data
// Notes:   included by both design files
`ifndef PEFC_REGS_SVH
`define PEFC_REGS_SVH
`define PEFC_ADDR_ENABLE     8'hEC
`define PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG     8'hF4
`define PEFC_ADDR_SWITCH     8'hF5
`define PEFC_ADDR_FLAGS      8'hF8
`define PEFC_ADDR_IRQ_PIN    8'hFF
`define PEFC_ADDR_KEY        8'hC1
`define PEFC_ADDR_ADC_START  8'hD8
`define PEFC_KEY_UNLOCK      8'hEA
`define PEFC_ZERO8           8'h00
// flag and enable bit positions
`define PEFC_B_RESTORED      7
`define PEFC_B_PSM           6
`define PEFC_B_DIP           5
`define PEFC_B_RSVD4         4
`define PEFC_B_DCADC         3
`define PEFC_B_BAT           2
`define PEFC_B_CHANGE        1
`define PEFC_B_DCLOW         0
// writable bits of the enable and flag registers
`define PEFC_ENABLE_MASK     8'hAF
`define PEFC_FLAGS_MASK      8'hEF
// peripheral register bit positions
`define PEFC_P_RXWAKE        7
`define PEFC_P_SOURCE        6
`define PEFC_P_MAINOK        5
`define PEFC_P_LOCKLOSS      4
`define PEFC_P_REFEN         3
`define PEFC_P_RXFN_HI       1
`define PEFC_P_RXFN_LO       0
// acknowledge bit inside the adc start register
`define PEFC_ADC_ACK_BIT     0
// switchover select and rx function codes
`define PEFC_SW_LOW_MAIN     2'h0
`define PEFC_SW_LOW_MAIN_DC  2'h1
`define PEFC_RX_GPIO         2'h0
`define PEFC_RX_NOWAKE       2'h1
`define PEFC_RX_WAKE         2'h3
`endif

// File: rtl/pefc_pkg.sv
// Purpose: shared types of the power event block
// Assumes: nothing beyond the register header
// Notes:   software write port is carried as one struct
package pefc_pkg;
  // one special-function register write or read
  typedef struct packed {
    logic       wr;    // write strobe, one cycle
    logic [7:0] addr;  // register address
    logic [7:0] data;  // write data
  } pefc_sfr_type;
  // switched supply source as seen by software
  typedef enum logic [1:0] {
    PEFC_SRC_MAIN = 2'h1,
    PEFC_SRC_BAT  = 2'h2
  } pefc_src_type;
endpackage

// File: rtl/pefc_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin-level inputs
// Assumes: input is asynchronous to i_core_clk
// Notes:   stage one feeds only stage two; a change counts once stages two and three agree
`timescale 1ns/100ps
`include "pefc_regs.svh"
module pefc_sync #(
  parameter int WIDTH = 1,                // number of bits
  parameter logic [WIDTH-1:0] INIT = '0   // value held from reset
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1;       // metastability stage
  logic [WIDTH-1:0] s2;       // second stage
  logic [WIDTH-1:0] s3;       // third stage
  logic [WIDTH-1:0] filt;     // agreed value
  logic [WIDTH-1:0] next_filt;
  // update only on bits where stages two and three agree
  always_comb begin
    next_filt = (s2 & s3) | (filt & (s2 | s3));
  end
  // register all stages
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s1   <= INIT;
      s2   <= INIT;
      s3   <= INIT;
      filt <= INIT;
    end else begin
      s1   <= i_async;
      s2   <= s1;
      s3   <= s2;
      filt <= next_filt;
    end
  end
  assign o_sync = filt;
endmodule // pefc_sync

// File: rtl/pefc_power_event_flags_ctrl.sv
// Purpose: power event flags, enables, switchover policy and supply status registers
// Assumes: core writes registers through a one-cycle strobe; reads are combinational
// Notes:   analog events arrive as pins and are synchronised here
// Notes on behaviour
// R01 - irq pin register writable only after key EA
// R02 - software returns key to zero afterwards
// R03 - bit 7 set on battery-to-main changeover
// R04 - bit 6 set on any enabled condition
// R05 - bit 5 set on voltage sag
// R06 - bit 3 set on dc input delta/ready
// R07 - bit 2 set on battery low/ready
// R08 - bit 1 set on main-to-battery changeover
// R09 - bit 0 set on dc input low
// R10 - switchover select codes 00, 01, 1X
// R11 - peripheral bit 7 marks rx wake-up
// R12 - peripheral bit 6 shows supply source
// R13 - peripheral bit 5 shows main supply ready
// R14 - lock loss flag cleared by ack only
// R15 - peripheral bit 3 keeps reference in sleep
// R16 - rx pin function codes 00, 01, 11
// R17 - enable bits gate flags onto interrupt
// R18 - software keeps reserved bits at zero
// R19 - interrupt is OR of enabled flags
// R20 - flags sticky, set beats software clear
`timescale 1ns/100ps
`include "pefc_regs.svh"
module pefc_power_event_flags_ctrl (
  input  wire logic                  i_core_clk,       // core clock, 40 MHz
  input  wire logic                  i_rst,            // synchronous reset, high
  input  wire pefc_pkg::pefc_sfr_type i_sfr,           // register write/addr
  output logic [7:0]                 o_sfr_rdata,      // read data at i_sfr.addr
  input  wire logic                  i_src_on_battery, // pin: switched out on battery
  input  wire logic                  i_main_ok,        // pin: main supply ready
  input  wire logic                  i_sag,            // pin: metering sag event
  input  wire logic                  i_dc_adc_event,   // pin: dc delta or ready
  input  wire logic                  i_bat_event,      // pin: battery low or ready
  input  wire logic                  i_dc_low,         // pin: dc input below 1.2 V
  input  wire logic                  i_lock_lost,      // pin: pll lost lock
  input  wire logic                  i_rx_wake,        // core: rx edge woke deep sleep
  output logic                       o_pm_irq,         // power-management interrupt
  output logic [1:0]                 o_switchover_select, // switchover policy
  output logic                       o_switch_on_low_main, // switchover armed on low main
  output logic                       o_switch_on_low_dc,   // switchover armed on low dc
  output logic                       o_standby_ref_enable, // keep reference in sleep
  output logic [1:0]                 o_rx_pin_function,    // rx pin function field
  output logic                       o_rx_serial,      // rx pin routed to serial port
  output logic                       o_rx_wake_enable, // rx edge may wake deep sleep
  output logic [7:0]                 o_irq_pin_config  // protected irq pin register
);
  import pefc_pkg::*;

  localparam int NEV = 6;  // synchronised event pins

  // synchronised pin levels
  logic [NEV-1:0] ev_sync;
  logic           src_bat;    // switched output fed from battery
  logic           main_ok;    // main supply ready
  logic           src_bat_d;  // previous source, for edges
  logic [NEV-1:0] ev_d;       // previous event levels

  // register state and next values
  logic [7:0] unlock_key_reg;
  logic [7:0] irq_pin_config_reg;
  logic [7:0] power_event_enable;
  logic [7:0] power_event_flags;
  logic [1:0] switchover_select;
  logic       rx_wake_flag;
  logic       lock_loss_flag;
  logic       standby_ref_enable;
  logic [1:0] rx_pin_function;
  logic       lock_d;         // previous lock-lost level
  logic       next_src_bat_d; // history follows the synced levels
  logic [NEV-1:0] next_ev_d;
  logic       next_lock_d;
  logic [7:0] next_unlock_key_reg;
  logic [7:0] next_irq_pin_config_reg;
  logic [7:0] next_power_event_enable;
  logic [7:0] next_power_event_flags;
  logic [1:0] next_switchover_select;
  logic       next_rx_wake_flag;
  logic       next_lock_loss_flag;
  logic       next_standby_ref_enable;
  logic [1:0] next_rx_pin_function;

  // decoded write strobes and event pulses
  logic       wr_key;         // key write
  logic       wr_irqpin;      // protected register write
  logic       wr_en;          // enable write
  logic       wr_flags;       // flag write, zero bits clear
  logic       wr_sw;          // switchover write
  logic       wr_peripheral_supply_config;      // peripheral write
  logic       wr_adc;         // adc start write, lock ack
  logic [7:0] hw_set;         // set events per flag bit, one-cycle except summary bit 6
  logic       pending;        // any enabled flag other than the summary bit
  pefc_src_type src_state;

  // address match for a write strobe
  function automatic logic wr_hit(input pefc_sfr_type s, input logic [7:0] a);
    return s.wr && (s.addr == a);
  endfunction

  // rising edge of a synced level against its history
  function automatic logic rising(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // synchronise the analog monitor pins; rx wake comes from core logic
  // source pin rides with the events: one shared latency
  // four edges pass before a pin level counts
  pefc_sync #(.WIDTH(NEV), .INIT(6'h00)) u_sync_ev (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    ({i_lock_lost, i_dc_low, i_bat_event, i_dc_adc_event, i_sag,
                  i_src_on_battery}),
    .o_sync     (ev_sync)
  );
  // main-ok resets to 1 so the status bit reads ready from reset
  pefc_sync #(.WIDTH(1), .INIT(1'h1)) u_sync_ok (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    (i_main_ok),
    .o_sync     (main_ok)
  );
  assign src_bat   = ev_sync[0];
  assign src_state = src_bat ? PEFC_SRC_BAT : PEFC_SRC_MAIN;  // R12

  // write decode
  always_comb begin
    wr_key    = wr_hit(i_sfr, `PEFC_ADDR_KEY);
    wr_irqpin = wr_hit(i_sfr, `PEFC_ADDR_IRQ_PIN);
    wr_en     = wr_hit(i_sfr, `PEFC_ADDR_ENABLE);
    wr_flags  = wr_hit(i_sfr, `PEFC_ADDR_FLAGS);
    wr_sw     = wr_hit(i_sfr, `PEFC_ADDR_SWITCH);
    wr_peripheral_supply_config = wr_hit(i_sfr, `PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG);
    wr_adc    = wr_hit(i_sfr, `PEFC_ADDR_ADC_START);
  end

  // hardware set pulses from rising edges of synchronised levels
  always_comb begin
    hw_set = `PEFC_ZERO8;
    // pulses last one cycle, as history trails by one edge
    // one flag per source direction
    hw_set[`PEFC_B_RESTORED] = rising(~src_bat, ~src_bat_d);  // R03
    hw_set[`PEFC_B_CHANGE]   = rising(src_bat, src_bat_d);    // R08
    // falling monitor levels are no events
    hw_set[`PEFC_B_DIP]      = rising(ev_sync[1], ev_d[1]);   // R05
    hw_set[`PEFC_B_DCADC]    = rising(ev_sync[2], ev_d[2]);   // R06
    hw_set[`PEFC_B_BAT]      = rising(ev_sync[3], ev_d[3]);   // R07
    hw_set[`PEFC_B_DCLOW]    = rising(ev_sync[4], ev_d[4]);   // R09
    // summary flag follows any enabled condition, new or pending
    pending = |(power_event_flags & power_event_enable & `PEFC_ENABLE_MASK);
    hw_set[`PEFC_B_PSM] = pending | |(hw_set & power_event_enable & `PEFC_ENABLE_MASK); // R04
  end

  // next values of software registers
  always_comb begin
    next_unlock_key_reg     = unlock_key_reg;
    next_irq_pin_config_reg = irq_pin_config_reg;
    next_power_event_enable = power_event_enable;
    next_switchover_select  = switchover_select;
    next_standby_ref_enable = standby_ref_enable;
    next_rx_pin_function    = rx_pin_function;
    next_rx_wake_flag       = rx_wake_flag;
    next_lock_loss_flag     = lock_loss_flag;
    next_power_event_flags  = power_event_flags;

    // key is left for software to return to zero
    // hazard: a key left at unlock keeps the register open
    if (wr_key) begin
      next_unlock_key_reg = i_sfr.data;  // R02
    end

    // protected register only while the key holds the unlock value
    // key is read before this edge: key and write may not
    // share one cycle, but may come back to back
    if (wr_irqpin && (unlock_key_reg == `PEFC_KEY_UNLOCK)) begin
      next_irq_pin_config_reg = i_sfr.data;  // R01
    end

    // reserved enable bits are not stored
    // bit 6 stays out, so the summary never feeds itself
    if (wr_en) begin
      next_power_event_enable = i_sfr.data & `PEFC_ENABLE_MASK;  // R17 R18
    end

    // only the select is stored
    if (wr_sw) begin
      next_switchover_select = i_sfr.data[1:0];  // R10
    end

    // peripheral: reference enable and rx function are writable; bit 7 clears on a zero write
    // bits 6, 5 and 4 are status, writes ignored
    if (wr_peripheral_supply_config) begin
      next_standby_ref_enable = i_sfr.data[`PEFC_P_REFEN];  // R15
      next_rx_pin_function    = i_sfr.data[`PEFC_P_RXFN_HI:`PEFC_P_RXFN_LO];  // R16
      // software may clear the wake flag by writing zero
      if (!i_sfr.data[`PEFC_P_RXWAKE]) begin
        next_rx_wake_flag = 1'b0;
      end
    end
    // a wake beats a clearing write
    if (i_rx_wake) begin
      next_rx_wake_flag = 1'b1;  // R11
    end

    // lock loss clears only on acknowledge; new loss wins
    // the adc start register is not stored here
    if (wr_adc && i_sfr.data[`PEFC_ADC_ACK_BIT]) begin
      next_lock_loss_flag = 1'b0;  // R14
    end
    if (rising(ev_sync[5], lock_d)) begin
      next_lock_loss_flag = 1'b1;  // R14
    end

    // flags: software writes zero to clear, a set event in the same cycle wins
    // a one keeps a flag, so other flags survive a write
    if (wr_flags) begin
      next_power_event_flags = power_event_flags & i_sfr.data;  // R20
    end
    next_power_event_flags = (next_power_event_flags | hw_set) & `PEFC_FLAGS_MASK;  // R20
  end

  // next values of the edge-detect history
  always_comb begin
    next_src_bat_d = src_bat;
    next_ev_d      = ev_sync;
    next_lock_d    = ev_sync[5];
  end

  // register all state
  // history resets to idle pin levels: no false event
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      unlock_key_reg     <= `PEFC_ZERO8;
      irq_pin_config_reg <= `PEFC_ZERO8;
      power_event_enable <= `PEFC_ZERO8;
      power_event_flags  <= `PEFC_ZERO8;
      switchover_select  <= `PEFC_SW_LOW_MAIN;
      rx_wake_flag       <= 1'b0;
      lock_loss_flag     <= 1'b0;
      standby_ref_enable <= 1'b0;
      rx_pin_function    <= `PEFC_RX_GPIO;
      src_bat_d          <= 1'b0;
      ev_d               <= '0;
      lock_d             <= 1'b0;
    end else begin
      unlock_key_reg     <= next_unlock_key_reg;
      irq_pin_config_reg <= next_irq_pin_config_reg;
      power_event_enable <= next_power_event_enable;
      power_event_flags  <= next_power_event_flags;
      switchover_select  <= next_switchover_select;
      rx_wake_flag       <= next_rx_wake_flag;
      lock_loss_flag     <= next_lock_loss_flag;
      standby_ref_enable <= next_standby_ref_enable;
      rx_pin_function    <= next_rx_pin_function;
      src_bat_d          <= next_src_bat_d;
      ev_d               <= next_ev_d;
      lock_d             <= next_lock_d;
    end
  end

  // read mux; unmapped addresses read zero
  // reads have no side effects: polling clears nothing
  always_comb begin
    o_sfr_rdata = `PEFC_ZERO8;
    unique case (i_sfr.addr)
      `PEFC_ADDR_ENABLE:  o_sfr_rdata = power_event_enable;
      `PEFC_ADDR_FLAGS:   o_sfr_rdata = power_event_flags;
      `PEFC_ADDR_SWITCH:  o_sfr_rdata = {6'h00, switchover_select};
      `PEFC_ADDR_IRQ_PIN: o_sfr_rdata = irq_pin_config_reg;
      `PEFC_ADDR_KEY:     o_sfr_rdata = unlock_key_reg;
      `PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG: begin
        o_sfr_rdata[`PEFC_P_RXWAKE]   = rx_wake_flag;                  // R11
        o_sfr_rdata[`PEFC_P_SOURCE]   = (src_state == PEFC_SRC_MAIN);  // R12
        o_sfr_rdata[`PEFC_P_MAINOK]   = main_ok;                       // R13
        o_sfr_rdata[`PEFC_P_LOCKLOSS] = lock_loss_flag;                // R14
        o_sfr_rdata[`PEFC_P_REFEN]    = standby_ref_enable;
        o_sfr_rdata[`PEFC_P_RXFN_HI:`PEFC_P_RXFN_LO] = rx_pin_function;
        // reserved bit 2 keeps the default zero
      end
      default:            o_sfr_rdata = `PEFC_ZERO8;
    endcase
  end

  // interrupt: any flag with its enable; held until software clears flags
  // bit 6 is masked, else the summary would hold the
  // request up after its cause was cleared
  assign o_pm_irq = |(power_event_flags & power_event_enable & `PEFC_ENABLE_MASK);  // R19 R17

  // decoded policy and pin function outputs
  // rx code 10 is unassigned and decodes as gpio
  always_comb begin
    o_switchover_select  = switchover_select;
    o_switch_on_low_main = ~switchover_select[1];                             // R10
    o_switch_on_low_dc   = (switchover_select == `PEFC_SW_LOW_MAIN_DC);       // R10
    o_standby_ref_enable = standby_ref_enable;                                // R15
    o_rx_pin_function    = rx_pin_function;
    o_rx_serial          = (rx_pin_function == `PEFC_RX_NOWAKE) ||
                           (rx_pin_function == `PEFC_RX_WAKE);                // R16
    o_rx_wake_enable     = (rx_pin_function == `PEFC_RX_WAKE);                // R16
    o_irq_pin_config     = irq_pin_config_reg;
  end
endmodule // pefc_power_event_flags_ctrl

// File: bench/pefc_properties.sv
// Purpose: port-level assertions for the power event block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   key and enable contents are mirrored from the write port
`timescale 1ns/100ps
`include "pefc_regs.svh"
module pefc_properties (
  input wire logic                   i_core_clk,
  input wire logic                   i_rst,
  input wire pefc_pkg::pefc_sfr_type i_sfr,
  input wire logic [7:0]             o_sfr_rdata,
  input wire logic                   o_pm_irq,
  input wire logic [1:0]             o_switchover_select,
  input wire logic                   o_switch_on_low_main,
  input wire logic                   o_switch_on_low_dc,
  input wire logic                   o_standby_ref_enable,
  input wire logic [1:0]             o_rx_pin_function,
  input wire logic                   o_rx_serial,
  input wire logic                   o_rx_wake_enable,
  input wire logic [7:0]             o_irq_pin_config
);
  import pefc_pkg::*;
  logic [7:0] key_q;      // last key written
  logic [7:0] en_q;       // copy of the enable register
  logic [7:0] next_key_q;
  logic [7:0] next_en_q;
  logic       wr_pin;     // write to the protected register
  logic       rd_flg;     // idle read of the flags
  logic       rd_per;     // idle read of the peripheral register
  assign wr_pin = i_sfr.wr && i_sfr.addr == `PEFC_ADDR_IRQ_PIN;
  assign rd_flg = !i_sfr.wr && i_sfr.addr == `PEFC_ADDR_FLAGS;
  assign rd_per = !i_sfr.wr && i_sfr.addr == `PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG;
  // mirrors follow writes only, so they never lean on design state
  always_comb begin
    next_key_q = key_q;
    next_en_q  = en_q;
    if (i_sfr.wr && i_sfr.addr == `PEFC_ADDR_KEY) next_key_q = i_sfr.data;
    if (i_sfr.wr && i_sfr.addr == `PEFC_ADDR_ENABLE) next_en_q = i_sfr.data & `PEFC_ENABLE_MASK;
  end
  // mirror registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      key_q <= 8'h00;
      en_q  <= 8'h00;
    end else begin
      key_q <= next_key_q;
      en_q  <= next_en_q;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  key_lock_a: assert property (
    wr_pin && key_q != `PEFC_KEY_UNLOCK |=> $stable(o_irq_pin_config))
    else $error("protected register changed while locked");
  key_open_a: assert property (
    wr_pin && key_q == `PEFC_KEY_UNLOCK |=> o_irq_pin_config == $past(i_sfr.data))
    else $error("protected register missed an unlocked write");
  switch_decode_a: assert property (
    o_switch_on_low_main == !o_switchover_select[1]
    && o_switch_on_low_dc == (o_switchover_select == `PEFC_SW_LOW_MAIN_DC))
    else $error("switchover decode wrong");
  switch_write_a: assert property (
    i_sfr.wr && i_sfr.addr == `PEFC_ADDR_SWITCH |=>
    o_switchover_select == $past(i_sfr.data[1:0]))
    else $error("switchover select not written");
  rx_decode_a: assert property (
    o_rx_pin_function != 2'h2 |-> o_rx_serial == (o_rx_pin_function != `PEFC_RX_GPIO)
    && o_rx_wake_enable == (o_rx_pin_function == `PEFC_RX_WAKE))
    else $error("rx function decode wrong");
  peripheral_supply_config_write_a: assert property (
    i_sfr.wr && i_sfr.addr == `PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG |=> o_standby_ref_enable ==
    $past(i_sfr.data[3]) && o_rx_pin_function == $past(i_sfr.data[1:0]))
    else $error("peripheral fields not written");
  irq_or_a: assert property (
    rd_flg |-> o_pm_irq == |(o_sfr_rdata & en_q))
    else $error("interrupt does not match enabled flags");
  flags_sticky_a: assert property (
    rd_flg ##1 i_sfr.addr == `PEFC_ADDR_FLAGS |->
    (o_sfr_rdata & $past(o_sfr_rdata)) == $past(o_sfr_rdata))
    else $error("flag dropped without a write");
  lock_hold_a: assert property (
    rd_per && o_sfr_rdata[4] ##1 i_sfr.addr == `PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG |-> o_sfr_rdata[4])
    else $error("lock loss flag dropped without ack");
  reset_peripheral_supply_config_a: assert property (
    $fell(i_rst) && i_sfr.addr == `PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG |-> o_sfr_rdata == 8'h60)
    else $error("peripheral register wrong after reset");
  open_write_c: cover property (wr_pin && key_q == `PEFC_KEY_UNLOCK);
  irq_high_c: cover property (rd_flg && o_pm_irq);
  lock_seen_c: cover property (rd_per && o_sfr_rdata[4]);
endmodule // pefc_properties
bind pefc_power_event_flags_ctrl pefc_properties i_pefc_properties (.i_core_clk, .i_rst,
  .i_sfr, .o_sfr_rdata, .o_pm_irq, .o_switchover_select, .o_switch_on_low_main,
  .o_switch_on_low_dc, .o_standby_ref_enable, .o_rx_pin_function, .o_rx_serial,
  .o_rx_wake_enable, .o_irq_pin_config);

// File: bench/pefc_power_event_flags_ctrl_bench.sv
// Purpose: directed register tests of the power event block
// Assumes: inputs change on the falling clock edge
// Notes:   pin events wait out the synchroniser before flags are read
`timescale 1ns/100ps
`include "pefc_regs.svh"
module pefc_power_event_flags_ctrl_bench;
  import pefc_pkg::*;
  logic         i_core_clk;       // 40 MHz core clock
  logic         i_rst;            // synchronous reset
  pefc_sfr_type i_sfr;            // register port
  logic         i_src_on_battery; // switched output on battery
  logic         i_main_ok;        // main supply ready
  logic         i_rx_wake;        // rx wake pulse
  logic [4:0]   ev;               // sag, dc adc, battery, dc low, lock loss
  logic [7:0]   o_sfr_rdata;
  logic         o_pm_irq;
  logic [1:0]   o_switchover_select;
  logic         o_switch_on_low_main;
  logic         o_switch_on_low_dc;
  logic         o_standby_ref_enable;
  logic [1:0]   o_rx_pin_function;
  logic         o_rx_serial;
  logic         o_rx_wake_enable;
  logic [7:0]   o_irq_pin_config;
  int           n_fail;           // mismatches
  int           checked;          // comparisons
  localparam logic [2:0] EV_BIT [4] = '{3'h5, 3'h3, 3'h2, 3'h0}; // flag of each event
  pefc_power_event_flags_ctrl i_pefc_power_event_flags_ctrl (.i_core_clk, .i_rst, .i_sfr,
    .o_sfr_rdata, .i_src_on_battery, .i_main_ok, .i_sag(ev[0]), .i_dc_adc_event(ev[1]),
    .i_bat_event(ev[2]), .i_dc_low(ev[3]), .i_lock_lost(ev[4]), .i_rx_wake, .o_pm_irq,
    .o_switchover_select, .o_switch_on_low_main, .o_switch_on_low_dc, .o_standby_ref_enable,
    .o_rx_pin_function, .o_rx_serial, .o_rx_wake_enable, .o_irq_pin_config);
  // clock
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one write strobe, then an idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    i_sfr = '{wr: 1'b1, addr: a, data: d};
    @(negedge i_core_clk);
    i_sfr.wr = 1'b0;
  endtask
  // compare once the address settles; return on a falling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_core_clk);
    i_sfr.addr = a;
    #1 chk(o_sfr_rdata, exp);
    @(negedge i_core_clk);
  endtask
  // synchroniser plus edge detect, with margin
  task automatic settle;
    repeat (8) @(negedge i_core_clk);
  endtask
  task automatic wrap_up;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog, far beyond the expected run of about 320 cycles
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
  // main sequence
  initial begin
    n_fail = 0;
    checked = 0;
    i_rst = 1'b1;
    i_sfr = '{wr: 1'b0, addr: `PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG, data: 8'h00};
    i_src_on_battery = 1'b0;
    i_main_ok = 1'b1;
    i_rx_wake = 1'b0;
    ev = 5'h00;
    repeat (6) @(negedge i_core_clk);
    i_rst = 1'b0;
    rd(`PEFC_ADDR_ENABLE, 8'h00);
    rd(`PEFC_ADDR_SWITCH, 8'h00);
    rd(`PEFC_ADDR_FLAGS, 8'h00);
    rd(`PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG, 8'h60);
    rd(8'h80, 8'h00);
    chk(8'(o_standby_ref_enable), 8'h00);
    $display("test reset values done");
    wr(`PEFC_ADDR_IRQ_PIN, 8'h80);
    rd(`PEFC_ADDR_IRQ_PIN, 8'h00);
    wr(`PEFC_ADDR_KEY, `PEFC_KEY_UNLOCK);
    wr(`PEFC_ADDR_IRQ_PIN, 8'h80);
    chk(o_irq_pin_config, 8'h80);
    wr(`PEFC_ADDR_KEY, 8'h00);
    wr(`PEFC_ADDR_IRQ_PIN, 8'h01);
    rd(`PEFC_ADDR_IRQ_PIN, 8'h80);
    $display("test key done");
    for (int i = 0; i < 4; i++) begin
      wr(`PEFC_ADDR_SWITCH, {6'h00, i[1:0]});
      rd(`PEFC_ADDR_SWITCH, {6'h00, i[1:0]});
      chk(8'(o_switchover_select), 8'(i[1:0]));
      chk(8'(o_switch_on_low_main), 8'(!i[1]));
      chk(8'(o_switch_on_low_dc), 8'(i == 1));
    end
    $display("test switchover done");
    for (int i = 0; i < 4; i++) begin
      if (i != 2) begin
        wr(`PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG, 8'h08 | 8'(i));
        rd(`PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG, 8'h68 | 8'(i));
        chk(8'(o_rx_serial), 8'(i != 0));
        chk(8'(o_rx_pin_function), 8'(i));
        chk(8'(o_rx_wake_enable), 8'(i == 3));
        chk(8'(o_standby_ref_enable), 8'h01);
      end
    end
    $display("test peripheral done");
    for (int j = 0; j < 2; j++) begin
      wr(`PEFC_ADDR_ENABLE, j ? 8'hAF : 8'h00);
      rd(`PEFC_ADDR_ENABLE, j ? 8'hAF : 8'h00);
      for (int k = 0; k < 4; k++) begin
        ev[k] = 1'b1;
        settle();
        ev[k] = 1'b0;
        settle();
        rd(`PEFC_ADDR_FLAGS, (8'h01 << EV_BIT[k]) | (j ? 8'h40 : 8'h00));
        chk(8'(o_pm_irq), 8'(j));
        wr(`PEFC_ADDR_FLAGS, 8'h40);
        wr(`PEFC_ADDR_FLAGS, 8'h00);
        rd(`PEFC_ADDR_FLAGS, 8'h00);
        chk(8'(o_pm_irq), 8'h00);
      end
    end
    $display("test flags done");
    i_src_on_battery = 1'b1;
    settle();
    rd(`PEFC_ADDR_FLAGS, 8'h42);
    rd(`PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG, 8'h2B);
    i_src_on_battery = 1'b0;
    settle();
    rd(`PEFC_ADDR_FLAGS, 8'hC2);
    rd(`PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG, 8'h6B);
    i_main_ok = 1'b0;
    settle();
    rd(`PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG, 8'h4B);
    i_main_ok = 1'b1;
    $display("test supply source done");
    ev[4] = 1'b1;
    settle();
    ev[4] = 1'b0;
    wr(`PEFC_ADDR_ADC_START, 8'h00);
    rd(`PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG, 8'h7B);
    wr(`PEFC_ADDR_ADC_START, 8'h01);
    rd(`PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG, 8'h6B);
    @(negedge i_core_clk);
    i_rx_wake = 1'b1;
    @(negedge i_core_clk);
    i_rx_wake = 1'b0;
    rd(`PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG, 8'hEB);
    wr(`PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG, 8'h0B);
    rd(`PEFC_ADDR_PERIPHERAL_SUPPLY_CONFIG, 8'h6B);
    $display("test lock loss and rx wake done");
    wrap_up();
  end
endmodule // pefc_power_event_flags_ctrl_bench
